// ### rtl/pfr_pkg.sv
// Register map, modes, types and reset values for the fault and retrigger PWM block
package pfr_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned CNT_W = 12;
	localparam int unsigned MTX_B_POS = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_IN_A = 4'h1;
	localparam logic [3:0] ADDR_IN_B = 4'h2;
	localparam logic [3:0] ADDR_DT_A = 4'h3;
	localparam logic [3:0] ADDR_OT_A = 4'h4;
	localparam logic [3:0] ADDR_DT_B = 4'h5;
	localparam logic [3:0] ADDR_OT_B = 4'h6;
	localparam logic [3:0] ADDR_MATRIX = 4'h7;
	localparam logic [3:0] ADDR_CAP_L = 4'h8;
	localparam logic [3:0] ADDR_CAP_H = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'ha;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [4:0] IN_RST = 5'h00;
	localparam logic [7:0] TIME_RST = 8'h01;
	localparam logic [7:0] MATRIX_RST = 8'h00;
	localparam logic [3:0] MODE_NONE = 4'h0;
	localparam logic [3:0] MODE_STOP_WAIT = 4'h1;
	localparam logic [3:0] MODE_PULSE_WAIT = 4'h2;
	localparam logic [3:0] MODE_PULSE_HOLD = 4'h3;
	localparam logic [3:0] MODE_KILL = 4'h4;
	localparam logic [3:0] MODE_DEAD = 4'h5;
	localparam logic [3:0] MODE_JUMP_DEAD = 4'h6;
	localparam logic [3:0] MODE_HALT = 4'h7;
	localparam logic [3:0] MODE_EDGE = 4'h8;
	localparam logic [3:0] MODE_FIX_EDGE = 4'h9;
	localparam logic [3:0] MODE_FIX_OFF = 4'he;
	typedef enum logic [1:0] {RUN_ONE = 2'h0, RUN_TWO = 2'h1, RUN_FOUR = 2'h2, RUN_CENTER = 2'h3} pfr_run_t;
	typedef enum logic [2:0] {
		PH_HALT = 3'b111,
		PH_DTA = 3'b000,
		PH_OTA = 3'b001,
		PH_DTB = 3'b011,
		PH_OTB = 3'b010,
		PH_WAIT = 3'b110
	} pfr_phase_t;
	typedef struct packed {
		logic dup_select_three;
		logic dup_select_two;
		logic mtx_en;
		logic output_polarity;
		pfr_run_t run_mode;
		logic run_bit;
	} pfr_ctrl_t;
	typedef struct packed {
		logic input_active_level;
		logic [3:0] input_mode_select;
	} pfr_in_cfg_t;
	typedef struct packed {
		logic a;
		logic b;
		logic two;
		logic three;
	} pfr_outs_t;
endpackage : pfr_pkg

// ### rtl/pfr_top.sv
// Fault and retrigger input handling, waveform sequencing and output matrix
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module pfr_top (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [pfr_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [pfr_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [pfr_pkg::DATA_W-1:0] reg_rdata_o,
	// Retrigger and fault inputs
	input wire logic fault_a_i,
	input wire logic fault_b_i,
	// Waveform outputs
	output logic wave_out_a_o,
	output logic wave_out_b_o,
	output logic ext_out_two_o,
	output logic ext_out_three_o
);
	pfr_pkg::pfr_ctrl_t ctrl_q;
	pfr_pkg::pfr_in_cfg_t in_cfg_q [2];
	logic [7:0] time_q [4];
	logic [7:0] matrix_q;
	logic [pfr_pkg::CNT_W-1:0] cap_q;
	logic [pfr_pkg::CNT_W-1:0] cnt_q;
	logic [pfr_pkg::CNT_W-1:0] ramp_q;
	pfr_pkg::pfr_phase_t ph_q;
	pfr_pkg::pfr_phase_t ph_d;
	pfr_pkg::pfr_phase_t nat;
	pfr_pkg::pfr_phase_t pend_at_q;
	pfr_pkg::pfr_phase_t pend_at_d;
	pfr_pkg::pfr_phase_t wait_next_q;
	pfr_pkg::pfr_phase_t wait_next_d;
	logic pend_q;
	logic pend_d;
	logic wait_src_q;
	logic wait_src_d;
	logic enter;
	logic halt_evt;
	logic ramp_start;
	logic done;
	logic one;
	logic running;
	logic force_all;
	logic mtx_on;
	logic [1:0] ridx;
	logic [7:0] cur_len;
	logic [1:0] fault_in;
	logic [1:0] act;
	logic [1:0] act_q;
	logic [1:0] edge_hit;
	logic [1:0] own_half;
	logic [1:0] own_on;
	logic [1:0] evt;
	logic [1:0] hold;
	logic [1:0] busy_q;
	logic [1:0] kill_q;
	logic [1:0] on_w;
	logic [3:0] mode_q [2];
	logic [pfr_pkg::DATA_W-1:0] rd_mux;
	pfr_pkg::pfr_outs_t outs_d;
	pfr_pkg::pfr_outs_t outs_q;

	assign fault_in = {fault_b_i, fault_a_i};
	assign mode_q[0] = in_cfg_q[0].input_mode_select;
	assign mode_q[1] = in_cfg_q[1].input_mode_select;
	assign one = ctrl_q.run_mode == pfr_pkg::RUN_ONE;
	assign running = ph_q == pfr_pkg::PH_DTA || ph_q == pfr_pkg::PH_OTA || ph_q == pfr_pkg::PH_DTB
		|| ph_q == pfr_pkg::PH_OTB;
	assign done = cnt_q >= {4'h0, cur_len};

	// Phase length and ramp index
	always_comb
	begin
		cur_len = time_q[0];
		ridx = 2'h0;
		case (ph_q)
			pfr_pkg::PH_OTA:
			begin
				cur_len = time_q[1];
				ridx = 2'h1;
			end
			pfr_pkg::PH_DTB:
			begin
				cur_len = time_q[2];
				ridx = 2'h2;
			end
			pfr_pkg::PH_OTB:
			begin
				cur_len = time_q[3];
				ridx = 2'h3;
			end
			default:
			begin
				cur_len = time_q[0];
				ridx = 2'h0;
			end
		endcase
	end

	// Input sense and event qualification
	always_comb
	begin
		force_all = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			act[i] = in_cfg_q[i].input_active_level ? fault_in[i] : ~fault_in[i];
			edge_hit[i] = act[i] & ~act_q[i];
			if (i == 0)
			begin
				own_half[i] = ph_q == pfr_pkg::PH_DTA || ph_q == pfr_pkg::PH_OTA;
				own_on[i] = ph_q == pfr_pkg::PH_OTA;
			end
			else
			begin
				own_half[i] = ph_q == pfr_pkg::PH_DTB || ph_q == pfr_pkg::PH_OTB;
				own_on[i] = ph_q == pfr_pkg::PH_OTB;
			end
			hold[i] = busy_q[i] & act[i] & (mode_q[i] == pfr_pkg::MODE_PULSE_HOLD);
			if (mode_q[i] == pfr_pkg::MODE_KILL && act[i])
				force_all = 1'b1;
			case (mode_q[i])
				pfr_pkg::MODE_STOP_WAIT, pfr_pkg::MODE_PULSE_WAIT, pfr_pkg::MODE_PULSE_HOLD:
					evt[i] = act[i] & ~busy_q[i] & (one ? running : own_half[i]);
				pfr_pkg::MODE_KILL, pfr_pkg::MODE_DEAD, pfr_pkg::MODE_JUMP_DEAD, pfr_pkg::MODE_HALT:
					evt[i] = act[i] & ~busy_q[i] & running;
				pfr_pkg::MODE_EDGE, pfr_pkg::MODE_FIX_EDGE, pfr_pkg::MODE_FIX_OFF:
					evt[i] = edge_hit[i] & own_on[i];
				default:
					evt[i] = 1'b0;
			endcase
		end
	end

	// Phase sequencer
	always_comb
	begin
		ph_d = ph_q;
		enter = 1'b0;
		halt_evt = 1'b0;
		pend_d = pend_q;
		pend_at_d = pend_at_q;
		wait_src_d = wait_src_q;
		wait_next_d = wait_next_q;
		case (ph_q)
			pfr_pkg::PH_DTA:
				if (hold[0])
					nat = pfr_pkg::PH_DTB;
				else
					nat = pfr_pkg::PH_OTA;
			pfr_pkg::PH_OTA:
				nat = pfr_pkg::PH_DTB;
			pfr_pkg::PH_DTB:
				if (hold[1])
					nat = pfr_pkg::PH_DTA;
				else
					nat = pfr_pkg::PH_OTB;
			default:
				nat = pfr_pkg::PH_DTA;
		endcase
		case (ph_q)
			pfr_pkg::PH_HALT:
				if (ctrl_q.run_bit)
				begin
					ph_d = pfr_pkg::PH_DTA;
					enter = 1'b1;
				end
			pfr_pkg::PH_WAIT:
				if (!act[wait_src_q])
				begin
					ph_d = wait_next_q;
					enter = 1'b1;
				end
			default:
				if (done)
				begin
					if (pend_q && ph_q == pend_at_q)
					begin
						ph_d = pfr_pkg::PH_WAIT;
						wait_next_d = nat;
						pend_d = 1'b0;
					end
					else
					begin
						ph_d = nat;
						enter = 1'b1;
					end
				end
		endcase
		for (int i = 1; i >= 0; i--)
		begin
			if (evt[i])
			begin
				case (mode_q[i])
					pfr_pkg::MODE_STOP_WAIT:
					begin
						ph_d = pfr_pkg::PH_WAIT;
						wait_src_d = (i == 1);
						pend_d = 1'b0;
						if (i == 0)
							wait_next_d = pfr_pkg::PH_DTB;
						else
							wait_next_d = pfr_pkg::PH_DTA;
					end
					pfr_pkg::MODE_PULSE_WAIT, pfr_pkg::MODE_PULSE_HOLD:
					begin
						enter = 1'b1;
						pend_d = mode_q[i] == pfr_pkg::MODE_PULSE_WAIT;
						wait_src_d = (i == 1);
						if (i == 0)
						begin
							ph_d = pfr_pkg::PH_DTB;
							pend_at_d = pfr_pkg::PH_OTB;
						end
						else
						begin
							ph_d = pfr_pkg::PH_DTA;
							pend_at_d = pfr_pkg::PH_OTA;
						end
					end
					pfr_pkg::MODE_DEAD:
						if (ph_q == pfr_pkg::PH_OTA || ph_q == pfr_pkg::PH_OTB)
						begin
							ph_d = nat;
							enter = 1'b1;
						end
					pfr_pkg::MODE_JUMP_DEAD:
					begin
						enter = 1'b1;
						pend_d = 1'b1;
						wait_src_d = (i == 1);
						if (own_half[0])
						begin
							ph_d = pfr_pkg::PH_DTB;
							pend_at_d = pfr_pkg::PH_DTB;
						end
						else
						begin
							ph_d = pfr_pkg::PH_DTA;
							pend_at_d = pfr_pkg::PH_DTA;
						end
					end
					pfr_pkg::MODE_HALT:
					begin
						ph_d = pfr_pkg::PH_HALT;
						halt_evt = 1'b1;
						pend_d = 1'b0;
					end
					pfr_pkg::MODE_EDGE:
					begin
						enter = 1'b1;
						if (one && i == 0)
							ph_d = pfr_pkg::PH_DTA;
						else
							ph_d = nat;
					end
					default:
						ph_d = ph_d;
				endcase
			end
		end
		if (!ctrl_q.run_bit || halt_evt)
		begin
			ph_d = pfr_pkg::PH_HALT;
			enter = 1'b0;
			pend_d = 1'b0;
		end
	end

	assign ramp_start = enter && (ctrl_q.run_mode == pfr_pkg::RUN_FOUR
		|| ph_d == pfr_pkg::PH_DTA || (!one && ph_d == pfr_pkg::PH_DTB));

	// Sequencer state
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			ph_q <= pfr_pkg::PH_HALT;
			pend_q <= 1'b0;
			pend_at_q <= pfr_pkg::PH_DTA;
			wait_src_q <= 1'b0;
			wait_next_q <= pfr_pkg::PH_DTA;
			cnt_q <= '0;
			ramp_q <= '0;
		end
		else
		begin
			ph_q <= ph_d;
			pend_q <= pend_d;
			pend_at_q <= pend_at_d;
			wait_src_q <= wait_src_d;
			wait_next_q <= wait_next_d;
			cnt_q <= enter ? '0 : cnt_q + 12'h001;
			ramp_q <= ramp_start ? '0 : ramp_q + 12'h001;
		end
	end

	// Input history, level latch and fixed-frequency kill
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			act_q <= 2'h3;
			busy_q <= 2'h0;
			kill_q <= 2'h0;
		end
		else
		begin
			act_q <= act;
			busy_q <= evt | (busy_q & act);
			for (int i = 0; i < 2; i++)
				kill_q[i] <= (kill_q[i] & ~ramp_start) | (evt[i] & (mode_q[i] == pfr_pkg::MODE_FIX_EDGE));
		end
	end

	// Capture of the ramp counter
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			cap_q <= '0;
		else if (|evt)
			cap_q <= ramp_q;
	end

	// Output shaping
	always_comb
	begin
		mtx_on = ctrl_q.mtx_en && ctrl_q.run_mode == pfr_pkg::RUN_FOUR;
		on_w[0] = own_on[0] & ~kill_q[0] & ~force_all & ~(mode_q[0] == pfr_pkg::MODE_FIX_OFF & act[0]);
		on_w[1] = own_on[1] & ~kill_q[1] & ~force_all & ~(mode_q[1] == pfr_pkg::MODE_FIX_OFF & act[1]);
		if (mtx_on)
		begin
			outs_d.a = running & matrix_q[ridx];
			outs_d.b = running & matrix_q[pfr_pkg::MTX_B_POS + ridx];
		end
		else
		begin
			outs_d.a = on_w[0] ^ ctrl_q.output_polarity;
			outs_d.b = on_w[1] ^ ctrl_q.output_polarity;
		end
		outs_d.two = ctrl_q.dup_select_two ? outs_d.b : outs_d.a;
		outs_d.three = ctrl_q.dup_select_three ? outs_d.a : outs_d.b;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			outs_q <= '0;
		else
			outs_q <= outs_d;
	end

	assign wave_out_a_o = outs_q.a;
	assign wave_out_b_o = outs_q.b;
	assign ext_out_two_o = outs_q.two;
	assign ext_out_three_o = outs_q.three;

	// Control register; a halting fault clears run after any write
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			ctrl_q <= pfr_pkg::pfr_ctrl_t'(pfr_pkg::CTRL_RST);
		else
		begin
			if (reg_we_i && reg_addr_i == pfr_pkg::ADDR_CTRL)
				ctrl_q <= pfr_pkg::pfr_ctrl_t'(reg_wdata_i[6:0]);
			if (halt_evt)
				ctrl_q.run_bit <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			in_cfg_q[0] <= pfr_pkg::pfr_in_cfg_t'(pfr_pkg::IN_RST);
			in_cfg_q[1] <= pfr_pkg::pfr_in_cfg_t'(pfr_pkg::IN_RST);
			for (int i = 0; i < 4; i++)
				time_q[i] <= pfr_pkg::TIME_RST;
			matrix_q <= pfr_pkg::MATRIX_RST;
		end
		else if (reg_we_i)
		begin
			case (reg_addr_i)
				pfr_pkg::ADDR_IN_A:
					in_cfg_q[0] <= pfr_pkg::pfr_in_cfg_t'(reg_wdata_i[4:0]);
				pfr_pkg::ADDR_IN_B:
					in_cfg_q[1] <= pfr_pkg::pfr_in_cfg_t'(reg_wdata_i[4:0]);
				pfr_pkg::ADDR_DT_A:
					time_q[0] <= reg_wdata_i;
				pfr_pkg::ADDR_OT_A:
					time_q[1] <= reg_wdata_i;
				pfr_pkg::ADDR_DT_B:
					time_q[2] <= reg_wdata_i;
				pfr_pkg::ADDR_OT_B:
					time_q[3] <= reg_wdata_i;
				pfr_pkg::ADDR_MATRIX:
					matrix_q <= reg_wdata_i;
				default:
					matrix_q <= matrix_q;
			endcase
		end
	end

	// Read path, data valid only in the cycle after the strobe
	always_comb
	begin
		case (reg_addr_i)
			pfr_pkg::ADDR_CTRL:
				rd_mux = {1'b0, ctrl_q};
			pfr_pkg::ADDR_IN_A:
				rd_mux = {3'h0, in_cfg_q[0]};
			pfr_pkg::ADDR_IN_B:
				rd_mux = {3'h0, in_cfg_q[1]};
			pfr_pkg::ADDR_DT_A:
				rd_mux = time_q[0];
			pfr_pkg::ADDR_OT_A:
				rd_mux = time_q[1];
			pfr_pkg::ADDR_DT_B:
				rd_mux = time_q[2];
			pfr_pkg::ADDR_OT_B:
				rd_mux = time_q[3];
			pfr_pkg::ADDR_MATRIX:
				rd_mux = matrix_q;
			pfr_pkg::ADDR_CAP_L:
				rd_mux = cap_q[7:0];
			pfr_pkg::ADDR_CAP_H:
				rd_mux = {4'h0, cap_q[11:8]};
			pfr_pkg::ADDR_STATUS:
				rd_mux = {kill_q, busy_q, 1'b0, ph_q};
			default:
				rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			reg_rdata_o <= 8'h00;
		else
			reg_rdata_o <= reg_re_i ? rd_mux : 8'h00;
	end

	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence halted_s;
		ph_q == pfr_pkg::PH_HALT && !ctrl_q.run_bit;
	endsequence
	sequence no_run_write_s;
		!(reg_we_i && reg_addr_i == pfr_pkg::ADDR_CTRL);
	endsequence

	fault_halts_a: assert property (evt[0] && mode_q[0] == pfr_pkg::MODE_HALT |=> halted_s)
		else $error("halt fault did not stop the sequencer");
	halt_holds_a: assert property (halted_s ##0 no_run_write_s |=> ph_q == pfr_pkg::PH_HALT)
		else $error("sequencer left halt without software");
	stop_wait_a: assert property (evt[0] && mode_q[0] == pfr_pkg::MODE_STOP_WAIT && ctrl_q.run_bit
		|=> ph_q == pfr_pkg::PH_WAIT && wait_next_q == pfr_pkg::PH_DTB)
		else $error("stop-and-wait did not enter wait");
	pulse_wait_a: assert property (evt[0] && mode_q[0] == pfr_pkg::MODE_PULSE_WAIT && ctrl_q.run_bit
		|=> ph_q == pfr_pkg::PH_DTB && pend_q && cnt_q == 12'h000)
		else $error("opposite pulse not started");
	kill_timing_a: assert property ((evt[0] && mode_q[0] == pfr_pkg::MODE_KILL && !evt[1]
		|| evt[1] && mode_q[1] == pfr_pkg::MODE_KILL && !evt[0]) && !done && ctrl_q.run_bit && !mtx_on
		|=> ph_q == $past(ph_q) && wave_out_a_o == $past(ctrl_q.output_polarity)
		&& wave_out_b_o == $past(ctrl_q.output_polarity))
		else $error("deactivate mode disturbed timing");
	edge_retrig_a: assert property (evt[0] && mode_q[0] == pfr_pkg::MODE_EDGE && !one && ctrl_q.run_bit
		|=> ph_q == pfr_pkg::PH_DTB)
		else $error("edge retrigger did not end on-time");
	ramp_reset_a: assert property (evt[0] && mode_q[0] == pfr_pkg::MODE_EDGE && one && ctrl_q.run_bit
		|=> ph_q == pfr_pkg::PH_DTA && ramp_q == 12'h000)
		else $error("one-ramp retrigger did not restart ramp");
	edge_window_a: assert property (mode_q[0] == pfr_pkg::MODE_EDGE && ph_q != pfr_pkg::PH_OTA |-> !evt[0])
		else $error("edge accepted outside on-time");
	fix_off_a: assert property (mode_q[0] == pfr_pkg::MODE_FIX_OFF && act[0] && !mtx_on
		|=> wave_out_a_o == $past(ctrl_q.output_polarity))
		else $error("output active while input active");
	capture_copy_a: assert property (|evt |=> cap_q == $past(ramp_q))
		else $error("capture missed counter value");
	matrix_bit_a: assert property (mtx_on && ph_q == pfr_pkg::PH_OTA |=> wave_out_a_o == $past(matrix_q[1]))
		else $error("matrix bit not driven");
	dup_two_a: assert property (ext_out_two_o == ($past(ctrl_q.dup_select_two) ? wave_out_b_o : wave_out_a_o))
		else $error("output two selection wrong");
	dup_three_a: assert property (ext_out_three_o == ($past(ctrl_q.dup_select_three) ? wave_out_a_o : wave_out_b_o))
		else $error("output three selection wrong");
endmodule : pfr_top

// ### sim/pfr_fault_src.sv
// Comparator model that feeds the fault inputs with a selectable response delay
`timescale 1ns/1ps
module pfr_fault_src (
	// Clock
	input wire logic ref_clk_i,
	// Requested comparator levels and response delay
	input wire logic level_a_i,
	input wire logic level_b_i,
	input wire logic [1:0] lat_i,
	// Fault lines, always driven
	output logic fault_a_o,
	output logic fault_b_o
);
	logic [3:0] pipe_a_q;
	logic [3:0] pipe_b_q;

	// Output settles one to four cycles after the request
	always_ff @(posedge ref_clk_i)
	begin
		pipe_a_q <= {pipe_a_q[2:0], level_a_i};
		pipe_b_q <= {pipe_b_q[2:0], level_b_i};
	end

	assign fault_a_o = pipe_a_q[lat_i];
	assign fault_b_o = pipe_b_q[lat_i];
endmodule : pfr_fault_src

// ### sim/test_pfr_top.sv
// Self-checking bench for the fault and retrigger waveform block
`timescale 1ns/1ps
module test_pfr_top;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [pfr_pkg::ADDR_W-1:0] reg_addr_i = 4'h0;
	logic [pfr_pkg::DATA_W-1:0] reg_wdata_i = 8'h00;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [pfr_pkg::DATA_W-1:0] reg_rdata_o;
	logic fault_a_i;
	logic fault_b_i;
	logic wave_out_a_o;
	logic wave_out_b_o;
	logic ext_out_two_o;
	logic ext_out_three_o;
	logic lvl_a = 1'b0;
	logic lvl_b = 1'b0;
	logic [1:0] lat = 2'h0;
	int num_errors = 0;
	int checked = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	pfr_fault_src u_src (
		.ref_clk_i(ref_clk_i),
		.level_a_i(lvl_a),
		.level_b_i(lvl_b),
		.lat_i(lat),
		.fault_a_o(fault_a_i),
		.fault_b_o(fault_b_i)
	);

	pfr_top u_dut (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o),
		.fault_a_i(fault_a_i),
		.fault_b_i(fault_b_i),
		.wave_out_a_o(wave_out_a_o),
		.wave_out_b_o(wave_out_b_o),
		.ext_out_two_o(ext_out_two_o),
		.ext_out_three_o(ext_out_three_o)
	);

	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("unexpected %s exp %h got %h", what, exp, got);
			num_errors++;
		end
	endtask : chk8

	task automatic chk1(input string what, input logic exp, input logic got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask : chk1

	task automatic chkn(input string what, input int exp, input int got);
		checked++;
		if (got != exp)
		begin
			$display("unexpected %s exp %0d got %0d", what, exp, got);
			num_errors++;
		end
	endtask : chkn

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_we_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_re_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd

	task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
		logic [7:0] d;
		rd(a, d);
		chk8(what, exp, d & m);
	endtask : rdchk

	// Fresh reset, then configuration with run last
	task automatic start(input logic [7:0] ia, input logic [7:0] ib, input logic [7:0] ot, input logic [7:0] mx,
		input logic [7:0] ctrl);
		reset_i <= 1'b1;
		lvl_a <= 1'b0;
		lvl_b <= 1'b0;
		lat <= 2'h0;
		repeat (5) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		wr(pfr_pkg::ADDR_IN_A, ia);
		wr(pfr_pkg::ADDR_IN_B, ib);
		wr(pfr_pkg::ADDR_OT_A, ot);
		wr(pfr_pkg::ADDR_OT_B, ot);
		wr(pfr_pkg::ADDR_MATRIX, mx);
		wr(pfr_pkg::ADDR_CTRL, ctrl);
	endtask : start

	task automatic wait_wave(input logic want_b, input int lim);
		int n;
		n = 0;
		while (((want_b ? wave_out_b_o : wave_out_a_o) !== 1'b1) && n < lim)
		begin
			@(posedge ref_clk_i);
			#1 n++;
		end
		chk1(want_b ? "wave_b rise" : "wave_a rise", 1'b1, want_b ? wave_out_b_o : wave_out_a_o);
	endtask : wait_wave

	task automatic count(input int n, input logic s2, input logic s3, output int ca, output int cb);
		ca = 0;
		cb = 0;
		repeat (n)
		begin
			@(posedge ref_clk_i);
			#1;
			if (wave_out_a_o === 1'b1) ca++;
			if (wave_out_b_o === 1'b1) cb++;
			chk1("ext_two", s2 ? wave_out_b_o : wave_out_a_o, ext_out_two_o);
			chk1("ext_three", s3 ? wave_out_a_o : wave_out_b_o, ext_out_three_o);
		end
	endtask : count

	task automatic t_regs;
		start(8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
		rdchk("ctrl", pfr_pkg::ADDR_CTRL, 8'h00, 8'hff);
		rdchk("dt_a", pfr_pkg::ADDR_DT_A, 8'h01, 8'hff);
		rdchk("status", pfr_pkg::ADDR_STATUS, 8'h07, 8'hff);
		rdchk("cap_l", pfr_pkg::ADDR_CAP_L, 8'h00, 8'hff);
		rdchk("unmapped", 4'hb, 8'h00, 8'hff);
		@(posedge ref_clk_i);
		#1 chk8("rdata idle", 8'h00, reg_rdata_o);
		wr(pfr_pkg::ADDR_IN_A, 8'hff);
		rdchk("in_a", pfr_pkg::ADDR_IN_A, 8'h1f, 8'hff);
	endtask : t_regs

	task automatic t_mode1;
		int ca;
		int cb;
		start(8'h11, 8'h00, 8'h07, 8'h00, 8'h03);
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rdchk("m1 phase", pfr_pkg::ADDR_STATUS, 8'h06, 8'h07);
		count(10, 1'b0, 1'b0, ca, cb);
		chkn("m1 held a", 0, ca);
		chkn("m1 held b", 0, cb);
		lvl_a <= 1'b0;
		wait_wave(1'b1, 12);
	endtask : t_mode1

	task automatic t_cut(input logic [3:0] m);
		int ca;
		int cb;
		start({4'h1, m}, 8'h00, 8'h07, 8'h00, 8'h03);
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 chk1("cut wave_a", 1'b0, wave_out_a_o);
		if (m == 4'h6)
		begin
			count(10, 1'b0, 1'b0, ca, cb);
			chkn("m6 wait b", 0, cb);
		end
		lvl_a <= 1'b0;
		wait_wave(1'b1, (m == 4'h6) ? 24 : 4);
	endtask : t_cut

	task automatic t_mode3;
		int ca;
		int cb;
		start(8'h13, 8'h00, 8'h07, 8'h00, 8'h03);
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		count(24, 1'b0, 1'b0, ca, cb);
		chkn("m3 own skipped", 0, ca);
		chkn("m3 opposite", 16, cb);
		lvl_a <= 1'b0;
		wait_wave(1'b0, 24);
	endtask : t_mode3

	task automatic t_halt;
		logic [7:0] c1;
		logic [7:0] c2;
		start(8'h17, 8'h00, 8'h1f, 8'h00, 8'h03);
		lat <= 2'h3;
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#1 chk1("halt wave_a", 1'b0, wave_out_a_o);
		rdchk("halt ctrl", pfr_pkg::ADDR_CTRL, 8'h02, 8'hff);
		rdchk("halt phase", pfr_pkg::ADDR_STATUS, 8'h07, 8'h07);
		rdchk("cap_h", pfr_pkg::ADDR_CAP_H, 8'h00, 8'hf0);
		rd(pfr_pkg::ADDR_CAP_L, c1);
		lvl_a <= 1'b0;
		lat <= 2'h0;
		wr(pfr_pkg::ADDR_CTRL, 8'h03);
		wait_wave(1'b0, 64);
		repeat (12) @(posedge ref_clk_i);
		lvl_a <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		rd(pfr_pkg::ADDR_CAP_L, c2);
		chk1("cap overwrite", 1'b1, c2 > c1);
	endtask : t_halt

	task automatic t_mode8;
		int ca;
		int cb;
		start(8'h18, 8'h00, 8'h0f, 8'h00, 8'h03);
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		wait_wave(1'b1, 6);
		lvl_a <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		lvl_a <= 1'b1;
		count(6, 1'b0, 1'b0, ca, cb);
		chkn("m8 stray edge", 6, cb);
	endtask : t_mode8

	task automatic t_one;
		start(8'h18, 8'h00, 8'h0f, 8'h00, 8'h01);
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 chk1("one-ramp cut", 1'b0, wave_out_a_o);
		wait_wave(1'b0, 3);
	endtask : t_one

	task automatic t_mode9;
		start(8'h19, 8'h00, 8'h0f, 8'h00, 8'h03);
		wait_wave(1'b0, 64);
		lvl_a <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 chk1("m9 kill", 1'b0, wave_out_a_o);
		wait_wave(1'b0, 40);
	endtask : t_mode9

	task automatic t_level(input logic [7:0] ia, input logic [7:0] ib, input int ea, input int eb);
		int ca;
		int cb;
		start(ia, ib, 8'h01, 8'h00, 8'h03);
		lvl_a <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		count(16, 1'b0, 1'b0, ca, cb);
		chkn("level a", ea, ca);
		chkn("level b", eb, cb);
	endtask : t_level

	task automatic t_inert;
		logic [3:0] m [6] = '{4'h0, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
		foreach (m[i])
			t_level({4'h1, m[i]}, 8'h00, 4, 4);
	endtask : t_inert

	task automatic t_matrix;
		int ca;
		int cb;
		start(8'h00, 8'h00, 8'h01, 8'h31, 8'h7d);
		repeat (4) @(posedge ref_clk_i);
		count(16, 1'b1, 1'b1, ca, cb);
		chkn("mtx a", 4, ca);
		chkn("mtx b", 8, cb);
		wr(pfr_pkg::ADDR_CTRL, 8'h1d);
		repeat (2) @(posedge ref_clk_i);
		count(16, 1'b0, 1'b0, ca, cb);
		chkn("mtx a again", 4, ca);
		chkn("mtx b again", 8, cb);
	endtask : t_matrix

	initial
	begin
		t_regs;
		t_mode1;
		t_cut(4'h2);
		t_cut(4'h5);
		t_cut(4'h6);
		t_mode3;
		t_halt;
		t_mode8;
		t_one;
		t_mode9;
		t_level(8'h1e, 8'h00, 0, 4);
		t_level(8'h00, 8'h04, 0, 0);
		lvl_b <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_inert;
		t_matrix;
		conclude;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		num_errors++;
		conclude;
	end
endmodule : test_pfr_top
